// ---- rtl/ssr_pkg.sv ----
// package: constants and carriers for the status and service request block
package ssr_pkg;
  localparam int STAT_NORMAL_BIT  = 7;
  localparam int STAT_SERVICE_BIT = 6;
  localparam int STAT_EVENT_BIT   = 5;
  localparam int STAT_MESSAGE_BIT = 4;
  localparam int STAT_FAULTQ_BIT  = 2;
  localparam int STAT_READY_BIT   = 0;
  localparam int EV_POWER_ON      = 7;
  localparam int EV_USER_REQUEST  = 6;
  localparam int EV_COMMAND_FAULT = 5;
  localparam int EV_RUN_FAULT     = 4;
  localparam int EV_DEVICE_FAULT  = 3;
  localparam int EV_QUERY_FAULT   = 2;
  localparam int EV_REQ_CONTROL   = 1;
  localparam int EV_DONE          = 0;
  localparam logic [7:0]  SVC_EN_RESET = 8'h00;
  localparam logic [7:0]  EV_EN_RESET  = 8'h00;
  localparam logic [7:0]  EV_RESET     = 8'h80;
  localparam logic [7:0]  STAT_USED    = 8'h75;
  localparam logic [7:0]  EV_USED      = 8'hFD;
  localparam logic [15:0] COND_RESET   = 16'h0000;
  localparam int          COND_WIDTH   = 16;

  typedef struct packed {
    logic user_request;
    logic command_fault;
    logic run_fault;
    logic device_fault;
    logic query_fault;
    logic done_flag;
  } ssr_events_s;

  typedef struct packed {
    logic       write;
    logic [7:0] data;
  } ssr_wr_s;
endpackage : ssr_pkg

// ---- rtl/ssr_event_reg.sv ----
// sticky event register with enable mask and summary
`timescale 1ns/1ps
module ssr_event_reg #(
  parameter int          WIDTH = 16,
  parameter logic [15:0] RST   = 16'h0000
) (
  input  wire logic             CLK,
  input  wire logic             RESET,
  input  wire logic [WIDTH-1:0] SET,
  input  wire logic             CLEAR,
  input  wire logic             ENABLE_WR,
  input  wire logic [WIDTH-1:0] ENABLE_DATA,
  output logic      [WIDTH-1:0] EVENTS,
  output logic      [WIDTH-1:0] ENABLE,
  output logic                  SUMMARY
);
  logic [WIDTH-1:0] next_events;
  logic [WIDTH-1:0] next_enable;

  always_comb begin
    // set wins over the clear in the same cycle
    next_events = (CLEAR ? '0 : EVENTS) | SET;
    next_enable = ENABLE_WR ? ENABLE_DATA : ENABLE;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      EVENTS <= RST[WIDTH-1:0];
      ENABLE <= '0;
    end else begin
      EVENTS <= next_events;
      ENABLE <= next_enable;
    end
  end

  assign SUMMARY = |(EVENTS & ENABLE);
endmodule : ssr_event_reg

// ---- rtl/ssr_top.sv ----
// status byte, standard events and service request logic
// Operation
// R1: eight-bit status byte with fixed bit positions
// R2: normal summary bit never set
// R3: poll returns request bit, query returns master
// R4: only enabled bits raise request; bit6 never
// R5: request bit set with line, cleared by poll
// R6: master summary read-only, clears with causes
// R7: event summary from enabled standard events
// R8: message available while reply queue nonempty
// R9: fault queue flag while error queue nonempty
// R10: eight-bit standard event register layout
// R11: event enable selects events; service enable gates
// R12: power-on flag set until read or cleared
// R13: user request on escape to local
// R14: command fault on command error
// R15: run fault on execution failure
// R16: device fault on internal error
// R17: query fault on protocol error
// R18: request control bit never set
// R19: done flag when all functions complete
// R20: serial port host must poll status
// R21: two sixteen-bit condition event registers
// R22: master summary is OR of enabled bits
`timescale 1ns/1ps
module ssr_top #(
  parameter int COND_W = 16
) (
  input  wire logic                 CLK,
  input  wire logic                 RESET,
  input  wire ssr_pkg::ssr_events_s EVENTS_IN,
  input  wire logic                 REPLY_QUEUE_NONEMPTY,
  input  wire logic                 ERROR_QUEUE_NONEMPTY,
  input  wire logic                 READY_SUMMARY,
  input  wire ssr_pkg::ssr_wr_s     SERVICE_ENABLE_WR,
  input  wire ssr_pkg::ssr_wr_s     EVENT_ENABLE_WR,
  input  wire logic                 STANDARD_EVENTS_RD,
  input  wire logic                 STANDARD_EVENTS_CLR,
  input  wire logic                 SERIAL_POLL,
  input  wire logic [COND_W-1:0]    NORMAL_SET,
  input  wire logic                 NORMAL_RD,
  input  wire logic                 NORMAL_ENABLE_WR,
  input  wire logic [COND_W-1:0]    NORMAL_ENABLE_DATA,
  input  wire logic [COND_W-1:0]    QUESTION_SET,
  input  wire logic                 QUESTION_RD,
  input  wire logic                 QUESTION_ENABLE_WR,
  input  wire logic [COND_W-1:0]    QUESTION_ENABLE_DATA,
  output logic      [7:0]           STATUS_QUERY,
  output logic      [7:0]           STATUS_POLL,
  output logic      [7:0]           SERVICE_ENABLE_MASK,
  output logic      [7:0]           STANDARD_EVENTS,
  output logic      [7:0]           EVENT_ENABLE,
  output logic      [COND_W-1:0]    NORMAL_EVENTS,
  output logic      [COND_W-1:0]    QUESTION_EVENTS,
  output logic                      NORMAL_SUMMARY,
  output logic                      QUESTION_SUMMARY,
  output logic                      SRQ_OUT
);
  import ssr_pkg::*;

  logic [7:0]  set_vec;
  logic        ev_clear;
  logic        event_summary;
  logic [7:0]  service_enable;
  logic [7:0]  next_service_enable;
  logic [7:0]  stat_base;
  logic        master_summary;
  logic        requested_service;
  logic        next_requested_service;
  logic        master_prev;
  logic        next_master_prev;
  logic [7:0]  next_status_query;
  logic [7:0]  next_status_poll;
  logic [7:0]  stat_query;
  logic [7:0]  stat_poll;

  always_comb begin
    set_vec                   = 8'h00;
    set_vec[EV_USER_REQUEST]  = EVENTS_IN.user_request;  // [R13]
    set_vec[EV_COMMAND_FAULT] = EVENTS_IN.command_fault; // [R14]
    set_vec[EV_RUN_FAULT]     = EVENTS_IN.run_fault;     // [R15]
    set_vec[EV_DEVICE_FAULT]  = EVENTS_IN.device_fault;  // [R16]
    set_vec[EV_QUERY_FAULT]   = EVENTS_IN.query_fault;   // [R17]
    set_vec[EV_DONE]          = EVENTS_IN.done_flag;     // [R19]
    // request control has no source: never the bus controller [R18]
    set_vec                   = set_vec & EV_USED;
  end

  // reading the event register clears it, power-on bit included [R12]
  assign ev_clear = STANDARD_EVENTS_RD | STANDARD_EVENTS_CLR;

  // standard events, reset value carries the power-on flag [R10] [R12]
  ssr_event_reg #(
    .WIDTH (8),
    .RST   ({8'h00, EV_RESET})
  ) u_std (
    .CLK         (CLK),
    .RESET       (RESET),
    .SET         (set_vec),
    .CLEAR       (ev_clear),
    .ENABLE_WR   (EVENT_ENABLE_WR.write),
    .ENABLE_DATA (EVENT_ENABLE_WR.data),
    .EVENTS      (STANDARD_EVENTS),
    .ENABLE      (EVENT_ENABLE),
    .SUMMARY     (event_summary)           // [R7] [R11]
  );

  // condition registers are read-clear; not tied into the status byte [R21]
  ssr_event_reg #(
    .WIDTH (COND_W),
    .RST   (COND_RESET)
  ) u_normal (
    .CLK         (CLK),
    .RESET       (RESET),
    .SET         (NORMAL_SET),
    .CLEAR       (NORMAL_RD),
    .ENABLE_WR   (NORMAL_ENABLE_WR),
    .ENABLE_DATA (NORMAL_ENABLE_DATA),
    .EVENTS      (NORMAL_EVENTS),
    .ENABLE      (),
    .SUMMARY     (NORMAL_SUMMARY)
  );

  ssr_event_reg #(
    .WIDTH (COND_W),
    .RST   (COND_RESET)
  ) u_question (
    .CLK         (CLK),
    .RESET       (RESET),
    .SET         (QUESTION_SET),
    .CLEAR       (QUESTION_RD),
    .ENABLE_WR   (QUESTION_ENABLE_WR),
    .ENABLE_DATA (QUESTION_ENABLE_DATA),
    .EVENTS      (QUESTION_EVENTS),
    .ENABLE      (),
    .SUMMARY     (QUESTION_SUMMARY)
  );

  always_comb begin
    stat_base                    = 8'h00;                   // [R1]
    stat_base[STAT_NORMAL_BIT]   = 1'b0;                    // [R2]
    stat_base[STAT_EVENT_BIT]    = event_summary;           // [R7]
    stat_base[STAT_MESSAGE_BIT]  = REPLY_QUEUE_NONEMPTY;    // [R8]
    stat_base[STAT_FAULTQ_BIT]   = ERROR_QUEUE_NONEMPTY;    // [R9]
    stat_base[STAT_READY_BIT]    = READY_SUMMARY;
    stat_base                    = stat_base & STAT_USED;
    // bit 6 masked out of the enable so it can never request [R4] [R22]
    master_summary = |(stat_base & service_enable & ~(8'h01 << STAT_SERVICE_BIT)); // [R6] [R11]
  end

  always_comb begin
    next_service_enable = SERVICE_ENABLE_WR.write ? SERVICE_ENABLE_WR.data : service_enable;
    next_master_prev    = master_summary;
    next_requested_service = requested_service;
    // a new request edge wins over a poll in the same cycle [R5]
    if (master_summary && !master_prev) begin
      next_requested_service = 1'b1;
    end else if (SERIAL_POLL) begin
      next_requested_service = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      service_enable    <= SVC_EN_RESET;
      requested_service <= 1'b0;
      master_prev       <= 1'b0;
    end else begin
      service_enable    <= next_service_enable;
      requested_service <= next_requested_service;
      master_prev       <= next_master_prev;
    end
  end

  always_comb begin
    stat_query                   = stat_base;
    stat_query[STAT_SERVICE_BIT] = master_summary;             // [R3] [R6]
    stat_poll                    = stat_base;
    stat_poll[STAT_SERVICE_BIT]  = next_requested_service;     // [R3] [R5]
    next_status_query            = stat_query;
    next_status_poll             = stat_poll;
  end

  // registered snapshots keep data outputs glitch free
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      STATUS_QUERY <= 8'h00;
      STATUS_POLL  <= 8'h00;
    end else begin
      STATUS_QUERY <= next_status_query;
      STATUS_POLL  <= next_status_poll;
    end
  end

  assign SERVICE_ENABLE_MASK = service_enable;
  // line asserted while the request bit stands; serial port host polls [R5] [R20]
  assign SRQ_OUT = requested_service;                    // [R22]
endmodule : ssr_top

// ---- verification/ssr_top_monitor.sv ----
// assertion checker for the status and service request block
`timescale 1ns/1ps
module ssr_top_monitor (
  input wire logic                 CLK,
  input wire logic                 RESET,
  input wire ssr_pkg::ssr_events_s EVENTS_IN,
  input wire logic                 STANDARD_EVENTS_RD,
  input wire logic                 SERIAL_POLL,
  input wire logic [7:0]           STATUS_QUERY,
  input wire logic [7:0]           STATUS_POLL,
  input wire logic [7:0]           STANDARD_EVENTS,
  input wire logic [7:0]           EVENT_ENABLE,
  input wire logic                 SRQ_OUT
);
  import ssr_pkg::*;
  logic [7:0] ev_map;
  logic [7:0] ev_on;
  // event struct bit positions differ from register positions: bits 7 and 1 have no source
  assign ev_map = {1'b0, EVENTS_IN[5:1], 1'b0, EVENTS_IN[0]};
  assign ev_on  = STANDARD_EVENTS & EVENT_ENABLE;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RESET);
  sequence poll_hit;
    SERIAL_POLL && SRQ_OUT;
  endsequence
  sequence line_low;
    !SRQ_OUT;
  endsequence
  unused_bits_a: assert property ((STATUS_QUERY & 8'h8A) == 8'h00)
    else $error("unused status bit set");
  views_match_a: assert property ((STATUS_QUERY & 8'hBF) == (STATUS_POLL & 8'hBF))
    else $error("poll and query views differ");
  request_line_a: assert property (STATUS_POLL[6] == SRQ_OUT)
    else $error("requested service differs from line");
  poll_clear_a: assert property (poll_hit |=> line_low)
    else $error("poll did not clear request");
  no_control_a: assert property (STANDARD_EVENTS[1] == 1'b0)
    else $error("request control bit set");
  read_clear_a: assert property (STANDARD_EVENTS_RD && ev_map == 8'h00 |=> STANDARD_EVENTS == 8'h00)
    else $error("standard events not cleared by read");
  events_stick_a: assert property (ev_map != 8'h00 |=> ($past(ev_map) & ~STANDARD_EVENTS) == 8'h00)
    else $error("event source not recorded");
  event_sum_a: assert property (STATUS_QUERY[5] == |$past(ev_on))
    else $error("event summary wrong");
  master_first_a: assert property ($rose(SRQ_OUT) |-> STATUS_QUERY[6])
    else $error("request without master summary");
endmodule : ssr_top_monitor

bind ssr_top ssr_top_monitor u_mon (.CLK, .RESET, .EVENTS_IN, .STANDARD_EVENTS_RD, .SERIAL_POLL,
  .STATUS_QUERY, .STATUS_POLL, .STANDARD_EVENTS, .EVENT_ENABLE, .SRQ_OUT);

// ---- verification/ssr_host_model.sv ----
// remote bus host model: serial polls after a service request
`timescale 1ns/1ps
module ssr_host_model #(
  parameter int DELAY = 6
) (
  input  wire logic       CLK,
  input  wire logic       RESET,
  input  wire logic       SRQ_OUT,
  input  wire logic [7:0] STATUS_POLL,
  output logic            SERIAL_POLL,
  output logic [7:0]      POLLED
);
  int wait_cnt;
  // a slow host: the request stands DELAY+1 cycles before the poll
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      wait_cnt    <= 0;
      SERIAL_POLL <= 1'b0;
      POLLED      <= 8'h00;
    end else begin
      SERIAL_POLL <= 1'b0;
      if (SRQ_OUT && !SERIAL_POLL) begin
        wait_cnt <= wait_cnt + 1;
        if (wait_cnt == DELAY) begin
          SERIAL_POLL <= 1'b1;
          POLLED      <= STATUS_POLL;
          wait_cnt    <= 0;
        end
      end
    end
  end
endmodule : ssr_host_model

// ---- verification/ssr_top_tb_top.sv ----
// self-checking bench for the status and service request block
`timescale 1ns/1ps
module ssr_top_tb_top;
  import ssr_pkg::*;
  logic        clk, reset, rq, eq, rdy, ev_rd, ev_clr, poll, srq, n_rd, n_ew, q_rd, q_ew, n_sum, q_sum;
  logic [15:0] n_set, n_ed, q_set, q_ed, n_ev, q_ev;
  logic [7:0]  stq, stp, svc_en, stdev, ev_en, polled;
  ssr_events_s ev;
  ssr_wr_s     svc_wr, ev_en_wr;
  int          n_fail, checks_done, cyc;
  int          pos [6] = '{0, 2, 3, 4, 5, 6};

  ssr_top dut (.CLK(clk), .RESET(reset), .EVENTS_IN(ev), .REPLY_QUEUE_NONEMPTY(rq), .ERROR_QUEUE_NONEMPTY(eq),
    .READY_SUMMARY(rdy), .SERVICE_ENABLE_WR(svc_wr), .EVENT_ENABLE_WR(ev_en_wr), .STANDARD_EVENTS_RD(ev_rd),
    .STANDARD_EVENTS_CLR(ev_clr), .SERIAL_POLL(poll), .NORMAL_SET(n_set), .NORMAL_RD(n_rd),
    .NORMAL_ENABLE_WR(n_ew), .NORMAL_ENABLE_DATA(n_ed), .QUESTION_SET(q_set), .QUESTION_RD(q_rd),
    .QUESTION_ENABLE_WR(q_ew), .QUESTION_ENABLE_DATA(q_ed), .STATUS_QUERY(stq), .STATUS_POLL(stp),
    .SERVICE_ENABLE_MASK(svc_en), .STANDARD_EVENTS(stdev), .EVENT_ENABLE(ev_en), .NORMAL_EVENTS(n_ev),
    .QUESTION_EVENTS(q_ev), .NORMAL_SUMMARY(n_sum), .QUESTION_SUMMARY(q_sum), .SRQ_OUT(srq));
  ssr_host_model host (.CLK(clk), .RESET(reset), .SRQ_OUT(srq), .STATUS_POLL(stp), .SERIAL_POLL(poll),
    .POLLED(polled));

  task automatic stop_test();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // wide enough for the joined views compared below, so no bit is cut off
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // sample one unit after the edge so that its updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic to_sre, input logic [7:0] d);
    @(posedge clk);
    if (to_sre) svc_wr <= '{1'b1, d};
    else ev_en_wr <= '{1'b1, d};
    @(posedge clk);
    svc_wr.write <= 1'b0;
    ev_en_wr.write <= 1'b0;
  endtask : wr
  task automatic rd_events();
    @(posedge clk);
    ev_rd <= 1'b1;
    @(posedge clk);
    ev_rd <= 1'b0;
  endtask : rd_events

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    {reset, rq, eq, rdy, ev_rd, ev_clr, n_rd, n_ew, q_rd, q_ew} = 10'h200;
    {n_set, n_ed, q_set, q_ed} = '0;
    ev = '0;
    svc_wr = '0;
    ev_en_wr = '0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    tick(1);
    chk(stdev, 8'h80);
    chk({svc_en, ev_en, stq}, 24'h000000);
    rd_events();
    tick(1);
    chk(stdev, 8'h00);
    wr(1'b1, 8'h40);
    rq <= 1'b1;
    tick(4);
    chk(srq, 1'b0);
    wr(1'b1, 8'h10);
    tick(3);
    chk({srq, stq, stp}, 17'h15050);
    tick(10);
    chk({srq, polled, stp}, 17'h05010);
    chk(stq, 8'h50);
    rq <= 1'b0;
    tick(3);
    chk(stq, 8'h00);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      ev <= ssr_events_s'(6'h01 << i);
      ev_rd <= 1'b0;
      @(posedge clk);
      ev <= '0;
      tick(1);
      chk(stdev, 8'h01 << pos[i]);
      @(posedge clk);
      ev_rd <= 1'b1;
    end
    // last read strobe must drop first, or it wipes the event set below
    @(posedge clk);
    ev_rd <= 1'b0;
    wr(1'b0, 8'h20);
    ev <= ssr_events_s'(6'h10);
    eq <= 1'b1;
    rdy <= 1'b1;
    @(posedge clk);
    ev <= '0;
    tick(3);
    chk(stq, 8'h25);
    wr(1'b0, 8'h00);
    tick(3);
    chk(stq, 8'h05);
    ev_clr <= 1'b1;
    @(posedge clk);
    ev_clr <= 1'b0;
    tick(1);
    chk(stdev, 8'h00);
    wr(1'b1, 8'h04);
    tick(3);
    chk(srq, 1'b1);
    chk({svc_en, ev_en}, 16'h0400);
    tick(10);
    chk(polled, 8'h45);
    n_ew <= 1'b1;
    n_ed <= 16'h8001;
    n_set <= 16'h8000;
    q_set <= 16'h0100;
    @(posedge clk);
    {n_ew, n_set, q_set} <= '0;
    tick(2);
    chk(n_ev, 16'h8000);
    chk({n_sum, q_ev, q_sum}, 18'h20200);
    n_rd <= 1'b1;
    q_ew <= 1'b1;
    q_ed <= 16'h0100;
    @(posedge clk);
    {n_rd, q_ew} <= 2'b00;
    tick(1);
    chk({n_ev, q_sum}, 17'h00001);
    q_rd <= 1'b1;
    @(posedge clk);
    q_rd <= 1'b0;
    tick(1);
    chk({q_ev, q_sum}, 17'h00000);
    stop_test();
  end
endmodule : ssr_top_tb_top
